//--- hw/pfsw_top.sv
// Notes on behaviour
// - every flash read returns exactly one 14-bit word
// - erase sets bits to one, programming only clears bits
// - flash is rows of 32 words; a row is the smallest erase
// - the array holds 4096 words, so addresses are 12 bits
// - after a row erase, all or part of the row may be programmed; here every row write programs all 32 words, unloaded ones with 3FFh
// - write latches are filled only through the data register pair
// - fetch and indirect paths only read the array
// - self-programming erases one row at most, never the whole array
// - erase or row-write start while address is write-protected sets the error flag
// - reset during a running self-write sets the error flag
// - an interrupted unlock sequence sets the error flag
// - error flag is sticky, software may set it and must clear it
// - erase-select start erases the whole addressed row, ignoring data
// - protected erase or row write: start cleared, error set, array untouched
// - latch-only start copies data into the latch picked by low address bits
// - row write programs latches into the row, then latches go to 3FFh
`timescale 1ns/100ps
`default_nettype none
module pfsw_top #(
   parameter int ERASE_CYCLES = pfsw_pkg::ERASE_CYC,
   parameter int WRITE_CYCLES = pfsw_pkg::WRITE_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic por_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [pfsw_pkg::PFSW_BUS_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [pfsw_pkg::PFSW_BUS_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [pfsw_pkg::PFSW_AW-1:0] fetch_addr,
   output logic [pfsw_pkg::PFSW_DW-1:0] fetch_data,
   input wire logic [pfsw_pkg::PFSW_AW-1:0] indirect_pointer,
   output logic [pfsw_pkg::PFSW_DW-1:0] indirect_data_port,
   output logic irq
);
   import pfsw_pkg::*;

   localparam int ERASE_WAIT = ERASE_CYCLES;
   localparam int WRITE_WAIT = WRITE_CYCLES;

   // bus slave state
   logic aw_hold_reg, w_hold_reg;
   logic [PFSW_BUS_AW-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   // register file and sequencer state
   logic start_reg, erase_sel_reg, latch_sel_reg;
   logic [1:0] unlock_stage_reg;
   logic [7:0] flash_addr_low_reg, flash_data_low_reg;
   logic [3:0] flash_addr_high_reg;
   logic [5:0] flash_data_high_reg;
   logic write_error_flag_reg;
   logic [1:0] irq_stat_reg, irq_mask_reg;
   logic [12:0] wp_start_reg;
   logic [PFSW_ROW_IDX_W-1:0] row_reg;
   logic [15:0] cnt_reg;
   pfsw_state_t state_reg;
   logic [PFSW_DW-1:0] latch_reg [PFSW_ROW_WORDS];
   logic [PFSW_ROW_WORDS*PFSW_DW-1:0] latch_flat;
   logic [PFSW_NRD*PFSW_DW-1:0] rd_flat;

   // write decode, one access per completed address and data pair
   wire bus_we = aw_hold_reg && w_hold_reg && !bvalid;
   wire lane0 = wstrb_reg[0];
   wire we_ctrl = bus_we && lane0 && waddr_reg == OFF_CTRL;
   wire we_unlock = bus_we && lane0 && waddr_reg == OFF_UNLOCK;
   wire we_addr_lo = bus_we && lane0 && waddr_reg == OFF_ADDR_LOW;
   wire we_addr_hi = bus_we && lane0 && waddr_reg == OFF_ADDR_HIGH;
   wire we_data_lo = bus_we && lane0 && waddr_reg == OFF_DATA_LOW;
   wire we_data_hi = bus_we && lane0 && waddr_reg == OFF_DATA_HIGH;
   wire we_stat = bus_we && lane0 && waddr_reg == OFF_STATUS;
   wire we_istat = bus_we && lane0 && waddr_reg == OFF_IRQ_STAT;
   wire we_imask = bus_we && lane0 && waddr_reg == OFF_IRQ_MASK;
   wire we_wp = bus_we && waddr_reg == OFF_WP_START;
   wire w_mapped = waddr_reg <= OFF_WP_START && waddr_reg[1:0] == 2'h0;

   // operation decode at the moment the start bit is written
   wire [PFSW_AW-1:0] flash_addr = {flash_addr_high_reg, flash_addr_low_reg};
   wire [PFSW_DW-1:0] flash_data = {flash_data_high_reg, flash_data_low_reg};
   wire busy = state_reg != ST_IDLE;
   wire start_req = we_ctrl && wdata_reg[CTRL_START_BIT] && !busy;
   wire key1_ok = we_unlock && wdata_reg[7:0] == UNLOCK_KEY1 && unlock_stage_reg == 2'h0;
   wire key2_ok = we_unlock && wdata_reg[7:0] == UNLOCK_KEY2 && unlock_stage_reg == 2'h1;
   wire go = start_req && unlock_stage_reg == 2'h2;
   wire erase_sel = wdata_reg[CTRL_ERASE_BIT];
   wire latch_sel = wdata_reg[CTRL_LATCH_BIT];
   // a start with no unlock counts as a broken sequence too
   wire unlock_err = (bus_we && unlock_stage_reg != 2'h0 && !key2_ok && !go)
      || (start_req && unlock_stage_reg == 2'h0);
   wire prot = {1'b0, flash_addr} >= wp_start_reg;
   wire reject = go && (erase_sel || !latch_sel) && prot;
   wire do_latch = go && !erase_sel && latch_sel;
   wire do_erase = go && erase_sel && !prot;
   wire do_write = go && !erase_sel && !latch_sel && !prot;
   wire op_end = busy && cnt_reg == 16'h0;
   wire erase_go = op_end && state_reg == ST_ERASE;
   wire prog_go = op_end && state_reg == ST_WRITE;
   wire hw_err_set = reject || unlock_err;
   wire [1:0] irq_set = {hw_err_set, op_end || do_latch};
   wire [1:0] irq_clr = we_istat ? wdata_reg[1:0] : 2'h0;

   // read mux, narrow registers sit in the low bits
   logic [31:0] rd_mux;
   wire r_mapped = araddr <= OFF_READ_DATA && araddr[1:0] == 2'h0;
   assign rd_mux =
      araddr == OFF_CTRL ? {29'h0, latch_sel_reg, erase_sel_reg, start_reg} :
      araddr == OFF_UNLOCK ? {30'h0, unlock_stage_reg} :
      araddr == OFF_ADDR_LOW ? {24'h0, flash_addr_low_reg} :
      araddr == OFF_ADDR_HIGH ? {28'h0, flash_addr_high_reg} :
      araddr == OFF_DATA_LOW ? {24'h0, flash_data_low_reg} :
      araddr == OFF_DATA_HIGH ? {26'h0, flash_data_high_reg} :
      araddr == OFF_STATUS ? {30'h0, busy, write_error_flag_reg} :
      araddr == OFF_IRQ_STAT ? {30'h0, irq_stat_reg} :
      araddr == OFF_IRQ_MASK ? {30'h0, irq_mask_reg} :
      araddr == OFF_WP_START ? {19'h0, wp_start_reg} :
      araddr == OFF_READ_DATA ? {18'h0, rd_flat[2*PFSW_DW +: PFSW_DW]} : 32'h0;

   // write address and data channels, taken in either order
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         waddr_reg <= '0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
      end else if (bvalid && bready) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
      end else begin
         if (awvalid && awready) begin
            aw_hold_reg <= 1'b1;
            awready <= 1'b0;
            waddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_reg <= 1'b1;
            wready <= 1'b0;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (bus_we) begin
         bvalid <= 1'b1;
         bresp <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read channel, data registered at the address handshake
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // plain control and data registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         erase_sel_reg <= 1'b0;
         latch_sel_reg <= 1'b0;
         flash_addr_low_reg <= 8'h0;
         flash_addr_high_reg <= 4'h0;
         flash_data_low_reg <= 8'h0;
         flash_data_high_reg <= 6'h0;
         irq_mask_reg <= 2'h0;
         wp_start_reg <= WP_START_RST;
      end else begin
         if (we_ctrl) erase_sel_reg <= erase_sel;
         if (we_ctrl) latch_sel_reg <= latch_sel;
         if (we_addr_lo) flash_addr_low_reg <= wdata_reg[7:0];
         if (we_addr_hi) flash_addr_high_reg <= wdata_reg[3:0];
         if (we_data_lo) flash_data_low_reg <= wdata_reg[7:0];
         if (we_data_hi) flash_data_high_reg <= wdata_reg[5:0];
         if (we_imask) irq_mask_reg <= wdata_reg[1:0];
         if (we_wp && wstrb_reg[0]) wp_start_reg[7:0] <= wdata_reg[7:0];
         if (we_wp && wstrb_reg[1]) wp_start_reg[12:8] <= wdata_reg[12:8];
      end
   end

   // unlock walks 55h then aaH then the start write; anything else breaks it
   always_ff @(posedge clk_sys) begin
      if (!rstn || go || unlock_err) begin
         unlock_stage_reg <= 2'h0;
      end else if (key1_ok) begin
         unlock_stage_reg <= 2'h1;
      end else if (key2_ok) begin
         unlock_stage_reg <= 2'h2;
      end
   end

   // sticky flag: power-on clears it, device reset keeps it
   always_ff @(posedge clk_sys) begin
      if (!por_n) begin
         write_error_flag_reg <= 1'b0;
      end else if (!rstn) begin
         if (busy) write_error_flag_reg <= 1'b1;
      end else if (hw_err_set) begin
         write_error_flag_reg <= 1'b1;
      end else if (we_stat) begin
         write_error_flag_reg <= wdata_reg[STAT_ERR_BIT];
      end
   end

   // sequencer: latch load ends at once, erase and write are timed
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         start_reg <= 1'b0;
         cnt_reg <= 16'h0;
         row_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (do_erase) begin
                  state_reg <= ST_ERASE;
                  start_reg <= 1'b1;
                  cnt_reg <= 16'(ERASE_WAIT - 1);
                  row_reg <= flash_addr[PFSW_AW-1:PFSW_ROW_AW];
               end else if (do_write) begin
                  state_reg <= ST_WRITE;
                  start_reg <= 1'b1;
                  cnt_reg <= 16'(WRITE_WAIT - 1);
                  row_reg <= flash_addr[PFSW_AW-1:PFSW_ROW_AW];
               end
            end
            ST_ERASE, ST_WRITE: begin
               if (op_end) begin
                  state_reg <= ST_IDLE;
                  start_reg <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg - 16'h1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               start_reg <= 1'b0;
            end
         endcase
      end
   end

   // write latches, reachable only through the data register pair
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < PFSW_ROW_WORDS; i++) begin
         if (!rstn || prog_go) begin
            latch_reg[i] <= LATCH_RST;
         end else if (do_latch && flash_addr[PFSW_ROW_AW-1:0] == PFSW_ROW_AW'(i)) begin
            latch_reg[i] <= flash_data;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < PFSW_ROW_WORDS; g++) begin : g_flat
         assign latch_flat[g*PFSW_DW +: PFSW_DW] = latch_reg[g];
      end
   endgenerate

   // interrupt status: set beats a write-one clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_stat_reg <= 2'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // fetch and indirect ports only ever address the read side
   pfsw_flash_array #(
      .WORDS(PFSW_WORDS),
      .DW(PFSW_DW),
      .ROW_WORDS(PFSW_ROW_WORDS),
      .NRD(PFSW_NRD)
   ) u_array (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .erase_go(erase_go),
      .prog_go(prog_go),
      .row_idx(row_reg),
      .prog_data(latch_flat),
      .rd_addr({flash_addr, indirect_pointer, fetch_addr}),
      .rd_data(rd_flat)
   );
   assign fetch_data = rd_flat[0 +: PFSW_DW];
   assign indirect_data_port = rd_flat[PFSW_DW +: PFSW_DW];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   prot_reject_a: assert property (reject |=> !start_reg && write_error_flag_reg
      && state_reg == ST_IDLE)
      else $error("protected start not rejected");
   latch_load_a: assert property (do_latch && !prog_go |=>
      latch_reg[$past(flash_addr[PFSW_ROW_AW-1:0])] == $past(flash_data) && !busy)
      else $error("latch not loaded");
   erase_time_a: assert property (do_erase |-> ##ERASE_WAIT erase_go)
      else $error("row erase not issued on time");
   write_time_a: assert property (do_write |-> ##WRITE_WAIT prog_go)
      else $error("row write not issued on time");
   latch_reset_a: assert property (prog_go |=> latch_reg[0] == LATCH_RST
      && latch_reg[PFSW_ROW_WORDS-1] == LATCH_RST)
      else $error("latches not reset after row write");
   unlock_break_a: assert property (unlock_err |=> write_error_flag_reg
      && unlock_stage_reg == 2'h0)
      else $error("broken unlock not flagged");
   reset_abort_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      !rstn && busy |=> write_error_flag_reg)
      else $error("reset during write not flagged");
   err_sticky_a: assert property (write_error_flag_reg && !we_stat |=>
      write_error_flag_reg)
      else $error("error flag cleared by hardware");
   done_clear_a: assert property (op_end |=> !start_reg && !busy
      && irq_stat_reg[IRQ_DONE_BIT])
      else $error("start bit not cleared at completion");
   prot_array_a: assert property (reject |=>
      (!busy && !erase_go && !prog_go) [*2])
      else $error("array touched on rejected start");

   erase_done_c: cover property (erase_go);
   write_done_c: cover property (prog_go);
   latch_load_c: cover property (do_latch);
   reject_c: cover property (reject);
endmodule
`default_nettype wire

//--- hw/pfsw_pkg.sv
package pfsw_pkg;
   // array geometry
   localparam int PFSW_AW = 12;
   localparam int PFSW_WORDS = 4096;
   localparam int PFSW_DW = 14;
   localparam int PFSW_ROW_WORDS = 32;
   localparam int PFSW_ROW_AW = 5;
   localparam int PFSW_ROW_IDX_W = PFSW_AW - PFSW_ROW_AW;
   localparam int PFSW_NRD = 3;
   localparam int PFSW_BUS_AW = 8;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_UNLOCK = 8'h04;
   localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
   localparam logic [7:0] OFF_ADDR_HIGH = 8'h0c;
   localparam logic [7:0] OFF_DATA_LOW = 8'h10;
   localparam logic [7:0] OFF_DATA_HIGH = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFF_WP_START = 8'h24;
   localparam logic [7:0] OFF_READ_DATA = 8'h28;

   // field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ERASE_BIT = 1;
   localparam int CTRL_LATCH_BIT = 2;
   localparam int STAT_ERR_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;

   // keys and reset values
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
   localparam logic [13:0] LATCH_RST = 14'h03ff;
   localparam logic [13:0] ERASED_WORD = 14'h3fff;
   localparam logic [12:0] WP_START_RST = 13'h1000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_ERASE_NS = 1000;
   localparam int T_WRITE_NS = 1000;
   localparam int ERASE_CYC = (T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} pfsw_state_t;
endpackage

//--- hw/pfsw_flash_array.sv
`timescale 1ns/100ps
`default_nettype none
module pfsw_flash_array #(
   parameter int WORDS = 4096,
   parameter int DW = 14,
   parameter int ROW_WORDS = 32,
   parameter int NRD = 3
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic erase_go,
   input wire logic prog_go,
   input wire logic [$clog2(WORDS/ROW_WORDS)-1:0] row_idx,
   input wire logic [ROW_WORDS*DW-1:0] prog_data,
   input wire logic [NRD*$clog2(WORDS)-1:0] rd_addr,
   output logic [NRD*DW-1:0] rd_data
);
   localparam int AW = $clog2(WORDS);
   localparam int RW = $clog2(ROW_WORDS);
   logic [DW-1:0] mem [WORDS];

   // array starts out erased
   initial begin
      for (int i = 0; i < WORDS; i++) begin
         mem[i] = '1;
      end
   end

   // erase only raises bits, programming only lowers them
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
         if (erase_go) begin
            mem[{row_idx, RW'(i)}] <= '1;
         end else if (prog_go) begin
            mem[{row_idx, RW'(i)}] <= mem[{row_idx, RW'(i)}] & prog_data[i*DW +: DW];
         end
      end
   end

   // independent read ports, one whole word each
   genvar g;
   generate
      for (g = 0; g < NRD; g++) begin : g_rd
         always_ff @(posedge clk_sys) begin
            rd_data[g*DW +: DW] <= mem[rd_addr[g*AW +: AW]];
         end
      end
   endgenerate

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   erase_ones_a: assert property (erase_go |=> mem[{$past(row_idx), RW'(0)}] == '1)
      else $error("erased word not all ones");
   prog_down_a: assert property (prog_go && !erase_go |=>
      (mem[{$past(row_idx), RW'(1)}] & ~$past(mem[{row_idx, RW'(1)}])) == '0)
      else $error("programming raised a bit");
endmodule
`default_nettype wire

//--- verification/pfsw_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// cpu side: instruction fetch and indirect pointer, both read only
module pfsw_cpu_model (
   input wire logic clk_sys,
   output logic [pfsw_pkg::PFSW_AW-1:0] fetch_addr,
   output logic [pfsw_pkg::PFSW_AW-1:0] indirect_pointer,
   input wire logic [pfsw_pkg::PFSW_DW-1:0] fetch_data,
   input wire logic [pfsw_pkg::PFSW_DW-1:0] indirect_data_port
);
   import pfsw_pkg::*;

   // distinct start points so a crossed path shows up
   initial begin
      fetch_addr = 12'h000;
      indirect_pointer = 12'hfff;
   end

   // both paths aim at one word; answer is a flop, so two edges pass
   task automatic peek(input logic [PFSW_AW-1:0] a, output logic [PFSW_DW-1:0] f,
      output logic [PFSW_DW-1:0] d);
      @(posedge clk_sys);
      fetch_addr <= a;
      indirect_pointer <= a;
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1;
      f = fetch_data;
      d = indirect_data_port;
   endtask
endmodule
`default_nettype wire

//--- verification/tb_program_flash_self_write.sv
`timescale 1ns/100ps
`default_nettype none
module tb_program_flash_self_write;
   import pfsw_pkg::*;
   logic clk_sys, rstn, por_n, awvalid, wvalid, bready, arvalid, rready, first_start;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rd;
   logic [3:0] wstrb;
   logic [1:0] resp;
   wire logic awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [PFSW_AW-1:0] fa, ip;
   wire logic [PFSW_DW-1:0] fd, idp;
   int bad_count, n_compared;

   // short timed counts keep the run small; erase long enough to be caught busy
   pfsw_top #(.ERASE_CYCLES(8), .WRITE_CYCLES(4)) dut (.clk_sys(clk_sys), .rstn(rstn),
      .por_n(por_n), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .fetch_addr(fa), .fetch_data(fd),
      .indirect_pointer(ip), .indirect_data_port(idp), .irq(irq));
   pfsw_cpu_model cpu (.clk_sys(clk_sys), .fetch_addr(fa), .indirect_pointer(ip),
      .fetch_data(fd), .indirect_data_port(idp));

   // 10 MHz system clock
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   // master write: aw and w offered together, each dropped once taken
   // no cycle limit here: a hang is left to the watchdog
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      resp = bresp;
      bready <= 1'h0;
   endtask

   // master read: rready held until rvalid is seen at an edge
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rd = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      rd_reg(a);
      cmp($sformatf("reg %h", a), e, rd);
   endtask

   task automatic chk_word(input logic [11:0] a, input logic [13:0] e);
      logic [13:0] f, d;
      cpu.peek(a, f, d);
      cmp($sformatf("fetch %h", a), {18'h0, e}, {18'h0, f});
      cmp($sformatf("indirect %h", a), {18'h0, e}, {18'h0, d});
   endtask

   // address and data pairs, high and low halves
   task automatic set_ad(input logic [11:0] a, input logic [13:0] d);
      wr(OFF_ADDR_LOW, {24'h0, a[7:0]});
      wr(OFF_ADDR_HIGH, {28'h0, a[11:8]});
      wr(OFF_DATA_LOW, {24'h0, d[7:0]});
      wr(OFF_DATA_HIGH, {26'h0, d[13:8]});
   endtask

   // unlock, start, then poll; first poll kept to see a running op
   task automatic op(input logic [31:0] c);
      int n;
      wr(OFF_UNLOCK, {24'h0, UNLOCK_KEY1});
      wr(OFF_UNLOCK, {24'h0, UNLOCK_KEY2});
      wr(OFF_CTRL, c);
      n = 0;
      do begin
         rd_reg(OFF_CTRL);
         if (n == 0) first_start = rd[CTRL_START_BIT];
         n++;
      end while (rd[CTRL_START_BIT] !== 1'h0 && n < 40);
      cmp("start bit", 32'h0, {31'h0, rd[CTRL_START_BIT]});
   endtask

   task automatic t_reset_vals();
      chk_reg(OFF_WP_START, {19'h0, WP_START_RST});
      chk_reg(OFF_STATUS, 32'h0);
      chk_reg(OFF_UNLOCK, 32'h0);
      chk_word(12'hfff, ERASED_WORD);
      chk_reg(8'h3c, 32'h0);
      cmp("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      wr(8'h3c, 32'h1);
      cmp("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
   endtask

   // one latch loaded, row written; untouched latches carry 3ffh
   task automatic t_latch_write();
      set_ad(12'h045, 14'h1234);
      op(32'h5);
      op(32'h1);
      chk_word(12'h045, 14'h1234);
      chk_word(12'h040, 14'h03ff);
      chk_word(12'h060, ERASED_WORD);
      chk_reg(OFF_READ_DATA, 32'h1234);
      set_ad(12'h065, 14'h0000);
      op(32'h1);
      chk_word(12'h065, 14'h03ff);
   endtask

   // erase with latch bit also set: whole row 2 only, data ignored
   task automatic t_erase();
      set_ad(12'h045, 14'h0000);
      op(32'h7);
      cmp("start while erasing", 32'h1, {31'h0, first_start});
      chk_word(12'h040, ERASED_WORD);
      chk_word(12'h05f, ERASED_WORD);
      chk_word(12'h065, 14'h03ff);
      chk_reg(OFF_IRQ_STAT, 32'h1);
      wr(OFF_IRQ_STAT, 32'h3);
      chk_reg(OFF_IRQ_STAT, 32'h0);
   endtask

   // protected row 3: erase and row write refused, latch load still taken
   task automatic t_protect();
      wr(OFF_WP_START, 32'h60);
      wr(OFF_IRQ_MASK, 32'h2);
      set_ad(12'h065, 14'h0000);
      op(32'h3);
      chk_reg(OFF_STATUS, 32'h1);
      chk_word(12'h065, 14'h03ff);
      cmp("irq on error", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_STAT, 32'h3);
      op(32'h5);
      chk_reg(OFF_IRQ_STAT, 32'h1);
      cmp("irq masked done", 32'h0, {31'h0, irq});
      op(32'h1);
      chk_word(12'h065, 14'h03ff);
      cmp("irq row write refused", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_STAT, 32'h3);
      chk_reg(OFF_IRQ_STAT, 32'h0);
      cmp("irq cleared", 32'h0, {31'h0, irq});
      wr(OFF_WP_START, {19'h0, WP_START_RST});
   endtask

   // flag survives a good op, software clears and sets it
   task automatic t_sticky();
      op(32'h5);
      chk_reg(OFF_STATUS, 32'h1);
      wr(OFF_STATUS, 32'h0);
      chk_reg(OFF_STATUS, 32'h0);
      wr(OFF_STATUS, 32'h1);
      chk_reg(OFF_STATUS, 32'h1);
      wr(OFF_STATUS, 32'h0);
   endtask

   // a foreign write between key and start breaks the unlock
   task automatic t_unlock();
      wr(OFF_UNLOCK, {24'h0, UNLOCK_KEY1});
      wr(OFF_ADDR_LOW, 32'h45);
      wr(OFF_CTRL, 32'h5);
      chk_reg(OFF_STATUS, 32'h1);
      chk_reg(OFF_UNLOCK, 32'h0);
      wr(OFF_STATUS, 32'h0);
   endtask

   // reset lands inside a timed erase; only power-on reset clears the flag
   task automatic t_reset_mid();
      wr(OFF_UNLOCK, {24'h0, UNLOCK_KEY1});
      wr(OFF_UNLOCK, {24'h0, UNLOCK_KEY2});
      wr(OFF_CTRL, 32'h3);
      rstn <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'h1;
      chk_reg(OFF_STATUS, 32'h1);
      @(posedge clk_sys);
      rstn <= 1'h0;
      por_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'h1;
      por_n <= 1'h1;
      chk_reg(OFF_STATUS, 32'h0);
   endtask

   // watchdog well beyond the expected few hundred cycles
   initial begin
      #(100 * 30000);
      bad_count++;
      end_sim();
   end

   // inputs quiet at time zero, reset for three cycles, then scenarios
   initial begin
      {rstn, por_n, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      bad_count = 0;
      n_compared = 0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'h1;
      por_n <= 1'h1;
      t_reset_vals();
      t_latch_write();
      t_erase();
      t_protect();
      t_sticky();
      t_unlock();
      t_reset_mid();
      end_sim();
   end
endmodule
`default_nettype wire
